// ### logic/acq_map.svh
// offsets, field positions, reset values and command words of the scan sequencer controller
`ifndef ACQ_MAP_SVH
`define ACQ_MAP_SVH
// software register offsets (apb, one word each)
`define REG_CMD 8'h00
`define REG_CFG 8'h04
`define REG_IV 8'h08
`define REG_CNT 8'h0c
`define REG_ENTRY 8'h10
`define REG_STATUS 8'h14
// command register bits
`define CMD_CLEAR 0
`define CMD_LOAD 1
`define CMD_PROG 2
`define CMD_START 3
// configuration register fields
`define CFG_ACQ 0
`define CFG_SEQ 1
`define CFG_DIV 2
`define CFG_EXT 3
`define CFG_TB_LO 4
`define CFG_TB_HI 6
// status register bits
`define ST_BUSY 0
`define ST_DONE 1
`define ST_REF 2
`define ST_BAD 3
// reset values
`define CFG_RST 7'h00
`define IV_RST 17'h00002
`define CNT_RST 4'h0
// device register offsets
`define DEV_ACQ_CLR 8'h00
`define DEV_ACQ_START 8'h02
`define DEV_SETUP_WIN 8'h04
`define DEV_SETUP_LD 8'h06
`define DEV_SETUP_CLR 8'h08
`define DEV_CMD1 8'h0a
`define DEV_CTR_DATA 8'h0c
`define DEV_CTR_CMD 8'h0e
// device command word 1 bits
`define DCMD_ACQ 0
`define DCMD_SEQ 1
`define DCMD_DIV 2
// interval counter command and data words
`define CNT_SEL_MODE3 16'hff03
`define CNT_SEL_LOAD3 16'hff0b
`define CNT_LOAD3 16'hff44
`define CNT_STEP3 16'hfff3
`define CNT_ARM3 16'hff24
`define CNT_DISARM3 16'hffc4
`define IV_PRELOAD 16'h0002
`define IV_MIN 17'h00002
`define IV_MAX 17'h10000
// timebase mode words
`define MODE_5MHZ 16'h8225
`define MODE_1MHZ 16'h8b25
`define MODE_100KHZ 16'h8c25
`define MODE_10KHZ 16'h8d25
`define MODE_1KHZ 16'h8e25
`define MODE_100HZ 16'h8f25
`define MODE_EXT 16'h8525
`define TB_LAST 3'h6
// setup entry end marker position
`define ENT_MARK_BIT 15
`endif

// ### logic/acq_pkg.sv
// types of the scan sequencer controller
`default_nettype none
package acq_pkg;
   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_ISSUE, S_WAIT} seq_st_t;
   typedef enum logic [1:0] {OP_CLEAR, OP_LOAD, OP_PROG, OP_START} op_t;
   typedef struct packed {
      seq_st_t st;
      op_t op;
      logic [2:0] step;
      logic [3:0] idx;
      logic [3:0] cnt_m1;
      logic acq_en;
      logic seq_en;
      logic div_adv;
      logic ext_paced;
      logic [2:0] tb_sel;
      logic [16:0] interval;
      logic done;
      logic refused;
      logic bad_iv;
      logic [31:0] prdata;
   } ctl_t;
   typedef struct packed {
      logic busy;
      logic penable;
      logic [7:0] addr;
      logic [15:0] data;
   } mst_t;
endpackage : acq_pkg
`default_nettype wire

// ### logic/acquisition_scan_sequencer.sv
// host controller that programs the acquisition board over its register bus
//
// How it works
// - a start command always strobes clear before starting conversions
// - one setup word per entry is written to the window, then load is strobed
// - setup clear is strobed before any setup entry is written
// - final entry carries the end marker; board wraps back to entry zero
// - load is clear, entries 0 to n-1 with marker on last, then load
// - mode word picks the timebase: six internal rates or external input
// - externally paced mode disarms the interval counter, pins go idle
// - counter programming: mode, load 2, load, step, interval, arm
// - interval 2 to ffff written as is, 10000 written as 0
// - every counter programming write is a 16-bit bus write
`timescale 1ns/100ps
`default_nettype none
`include "acq_map.svh"
module acquisition_scan_sequencer
   import acq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic dev_psel,
   output logic dev_penable,
   output logic dev_pwrite,
   output logic [7:0] dev_paddr,
   output logic [31:0] dev_pwdata,
   input wire logic dev_pready
);
   localparam ctl_t CTL_RST = '{
      st: S_IDLE,
      op: OP_CLEAR,
      step: 3'h0,
      idx: 4'h0,
      cnt_m1: `CNT_RST,
      acq_en: 1'(`CFG_RST >> `CFG_ACQ),
      seq_en: 1'(`CFG_RST >> `CFG_SEQ),
      div_adv: 1'(`CFG_RST >> `CFG_DIV),
      ext_paced: 1'(`CFG_RST >> `CFG_EXT),
      tb_sel: 3'(`CFG_RST >> `CFG_TB_LO),
      interval: `IV_RST,
      done: 1'b0,
      refused: 1'b0,
      bad_iv: 1'b0,
      prdata: 32'h0000_0000
   };

   ctl_t r;
   ctl_t n;
   logic wr_en;
   logic busy;
   logic acc;
   op_t new_op;
   logic cmd_hit;
   logic cfg_hit;
   logic mem_we;
   logic [14:0] ent;
   logic w_last;
   logic [7:0] m_addr;
   logic [15:0] m_data;
   logic m_req;
   logic m_done;

   // timebase selector to counter mode word
   function automatic logic [15:0] mode_word(input logic [2:0] sel);
      logic [15:0] w;
      w = `MODE_5MHZ;
      unique case (sel)
         3'h0: w = `MODE_5MHZ;
         3'h1: w = `MODE_1MHZ;
         3'h2: w = `MODE_100KHZ;
         3'h3: w = `MODE_10KHZ;
         3'h4: w = `MODE_1KHZ;
         3'h5: w = `MODE_100HZ;
         default: w = `MODE_EXT;
      endcase
      return w;
   endfunction : mode_word

   // interval of 65536 is carried as zero in the 16-bit load value
   function automatic logic [15:0] iv_enc(input logic [16:0] iv);
      return (iv == `IV_MAX) ? 16'h0000 : iv[15:0];
   endfunction : iv_enc

   function automatic logic prog_ok(input ctl_t c);
      return c.ext_paced ||
         (c.interval >= `IV_MIN && c.interval <= `IV_MAX && c.tb_sel <= `TB_LAST);
   endfunction : prog_ok

   function automatic logic is_mapped(input logic [7:0] a);
      return a == `REG_CMD || a == `REG_CFG || a == `REG_IV || a == `REG_CNT ||
         a == `REG_ENTRY || a == `REG_STATUS;
   endfunction : is_mapped

   // current device write of the running operation: {last, address, data}
   function automatic logic [24:0] step_word(input ctl_t c, input logic [14:0] e);
      logic [24:0] w;
      w = {1'b1, `DEV_ACQ_CLR, 16'h0000};
      unique case (c.op)
         OP_CLEAR: w = {1'b1, `DEV_ACQ_CLR, 16'h0000};
         OP_LOAD: begin
            unique case (c.step)
               3'h0: w = {1'b0, `DEV_SETUP_CLR, 16'h0000};
               3'h1: w = {1'b0, `DEV_SETUP_WIN, c.idx == c.cnt_m1, e};
               default: w = {1'b1, `DEV_SETUP_LD, 16'h0000};
            endcase
         end
         OP_PROG: begin
            if (c.ext_paced) begin
               w = {1'b1, `DEV_CTR_CMD, `CNT_DISARM3};
            end else begin
               unique case (c.step)
                  3'h0: w = {1'b0, `DEV_CTR_CMD, `CNT_SEL_MODE3};
                  3'h1: w = {1'b0, `DEV_CTR_DATA, mode_word(c.tb_sel)};
                  3'h2: w = {1'b0, `DEV_CTR_CMD, `CNT_SEL_LOAD3};
                  3'h3: w = {1'b0, `DEV_CTR_DATA, `IV_PRELOAD};
                  3'h4: w = {1'b0, `DEV_CTR_CMD, `CNT_LOAD3};
                  3'h5: w = {1'b0, `DEV_CTR_CMD, `CNT_STEP3};
                  3'h6: w = {1'b0, `DEV_CTR_DATA, iv_enc(c.interval)};
                  3'h7: w = {1'b1, `DEV_CTR_CMD, `CNT_ARM3};
               endcase
            end
         end
         OP_START: begin
            unique case (c.step)
               3'h0: w = {1'b0, `DEV_ACQ_CLR, 16'h0000};
               3'h1: w = {1'b0, `DEV_CMD1, 13'h0000, c.div_adv, c.seq_en, c.acq_en};
               default: w = {1'b1, `DEV_ACQ_START, 16'h0000};
            endcase
         end
      endcase
      return w;
   endfunction : step_word

   setup_entry_mem u_mem (
      .clk_sys(clk_sys),
      .we(mem_we),
      .waddr(pwdata[19:16]),
      .wdata(pwdata[14:0]),
      .raddr(r.idx),
      .rdata(ent)
   );

   dev_bus_master u_mst (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .req(m_req),
      .req_addr(m_addr),
      .req_data(m_data),
      .done(m_done),
      .dev_psel(dev_psel),
      .dev_penable(dev_penable),
      .dev_pwrite(dev_pwrite),
      .dev_paddr(dev_paddr),
      .dev_pwdata(dev_pwdata),
      .dev_pready(dev_pready)
   );

   assign pready = 1'b1;
   assign pslverr = psel && penable && !is_mapped(paddr);
   assign prdata = r.prdata;
   assign {w_last, m_addr, m_data} = step_word(r, ent);

   // decode of software writes
   always_comb begin
      wr_en = psel && penable && pwrite;
      busy = r.st != S_IDLE;
      cmd_hit = wr_en && paddr == `REG_CMD && pwdata[3:0] != 4'h0;
      cfg_hit = wr_en && (paddr == `REG_CFG || paddr == `REG_IV || paddr == `REG_CNT);
      mem_we = wr_en && paddr == `REG_ENTRY;
      if (pwdata[`CMD_CLEAR]) begin
         new_op = OP_CLEAR;
      end else if (pwdata[`CMD_LOAD]) begin
         new_op = OP_LOAD;
      end else if (pwdata[`CMD_PROG]) begin
         new_op = OP_PROG;
      end else begin
         new_op = OP_START;
      end
      acc = cmd_hit && !busy && !(new_op == OP_PROG && !prog_ok(r));
   end

   always_comb begin
      n = r;
      m_req = 1'b0;
      // settings are frozen while an operation runs
      if (cfg_hit && !busy) begin
         if (paddr == `REG_CFG) begin
            n.acq_en = pwdata[`CFG_ACQ];
            n.seq_en = pwdata[`CFG_SEQ];
            n.div_adv = pwdata[`CFG_DIV];
            n.ext_paced = pwdata[`CFG_EXT];
            n.tb_sel = pwdata[`CFG_TB_HI:`CFG_TB_LO];
         end else if (paddr == `REG_IV) begin
            n.interval = pwdata[16:0];
         end else begin
            n.cnt_m1 = pwdata[3:0];
         end
      end
      // write one to clear; a set in the same cycle wins
      if (wr_en && paddr == `REG_STATUS) begin
         n.done = r.done && !pwdata[`ST_DONE];
         n.refused = r.refused && !pwdata[`ST_REF];
         n.bad_iv = r.bad_iv && !pwdata[`ST_BAD];
      end
      if ((cmd_hit || cfg_hit) && busy) begin
         n.refused = 1'b1;
      end
      if (cmd_hit && !busy && new_op == OP_PROG && !prog_ok(r)) begin
         n.bad_iv = 1'b1;
      end
      unique case (r.st)
         S_IDLE: begin
            if (acc) begin
               n.st = S_FETCH;
               n.op = new_op;
               n.step = 3'h0;
               n.idx = 4'h0;
            end
         end
         S_FETCH: n.st = S_ISSUE;
         S_ISSUE: begin
            m_req = 1'b1;
            n.st = S_WAIT;
         end
         S_WAIT: begin
            if (m_done) begin
               if (w_last) begin
                  n.st = S_IDLE;
                  n.done = 1'b1;
               end else begin
                  n.st = S_FETCH;
                  if (r.op == OP_LOAD && r.step == 3'h1) begin
                     // entries go to consecutive locations 0 .. n-1
                     if (r.idx == r.cnt_m1) begin
                        n.step = 3'h2;
                     end else begin
                        n.idx = r.idx + 4'h1;
                     end
                  end else begin
                     n.step = r.step + 3'h1;
                  end
               end
            end
         end
      endcase
      // read data captured in the setup phase
      if (psel && !penable) begin
         n.prdata = 32'h0000_0000;
         unique case (paddr)
            `REG_CFG: n.prdata = {25'h0, r.tb_sel, r.ext_paced, r.div_adv, r.seq_en, r.acq_en};
            `REG_IV: n.prdata = {15'h0, r.interval};
            `REG_CNT: n.prdata = {28'h0, r.cnt_m1};
            `REG_STATUS: n.prdata = {28'h0, r.bad_iv, r.refused, r.done, busy};
            default: n.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r <= CTL_RST;
      end else begin
         r <= n;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_issue(logic [7:0] a);
      m_req && m_addr == a;
   endsequence

   sequence s_accept(op_t o);
      acc && new_op == o;
   endsequence

   a_clear_strobe: assert property (s_accept(OP_CLEAR) |-> ##2 s_issue(`DEV_ACQ_CLR))
      else $error("clear command did not strobe acquisition clear");
   a_start_clears: assert property (s_accept(OP_START) |-> ##2 s_issue(`DEV_ACQ_CLR))
      else $error("start did not clear the board first");
   a_load_opens: assert property (s_accept(OP_LOAD) |-> ##2 s_issue(`DEV_SETUP_CLR))
      else $error("setup load did not begin with setup clear");
   a_marker_last: assert property (m_req && m_addr == `DEV_SETUP_WIN |->
      m_data[`ENT_MARK_BIT] == (r.idx == r.cnt_m1))
      else $error("end marker on wrong entry");
   a_load_strobe: assert property (s_issue(`DEV_SETUP_LD) |->
      r.op == OP_LOAD && r.idx == r.cnt_m1 && w_last)
      else $error("setup load strobed before all entries");
   a_load_after_win: assert property (m_done && r.op == OP_LOAD && r.step == 3'h1
      && r.idx == r.cnt_m1 |-> ##2 s_issue(`DEV_SETUP_LD))
      else $error("load strobe did not follow final entry");
   a_mode_word: assert property (m_req && r.op == OP_PROG && r.step == 3'h1 && !r.ext_paced
      |-> m_addr == `DEV_CTR_DATA && m_data == mode_word(r.tb_sel))
      else $error("wrong timebase mode word");
   a_interval_enc: assert property (m_req && r.op == OP_PROG && r.step == 3'h6
      |-> (r.interval[16] ? m_data == 16'h0000 : m_data == r.interval[15:0]))
      else $error("interval load value misencoded");
   a_arm_follows: assert property (m_done && r.op == OP_PROG && r.step == 3'h6
      |-> ##2 (s_issue(`DEV_CTR_CMD) ##0 m_data == `CNT_ARM3))
      else $error("counter not armed after interval");
   a_ext_disarm: assert property (s_accept(OP_PROG) ##0 r.ext_paced
      |-> ##2 (s_issue(`DEV_CTR_CMD) ##0 (m_data == `CNT_DISARM3 && w_last)))
      else $error("paced mode did not disarm counter");
   a_scan_bits: assert property (s_issue(`DEV_CMD1) |->
      m_data[`DCMD_SEQ] == r.seq_en && m_data[`DCMD_ACQ] == r.acq_en)
      else $error("scan enable bits wrong");
   a_divadv_bit: assert property (s_issue(`DEV_CMD1) |-> m_data[`DCMD_DIV] == r.div_adv)
      else $error("divider advance bit wrong");
endmodule : acquisition_scan_sequencer
`default_nettype wire

// ### logic/dev_bus_master.sv
// write-only apb master toward the board's registers, 16-bit data
`timescale 1ns/100ps
`default_nettype none
module dev_bus_master
   import acq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic req,
   input wire logic [7:0] req_addr,
   input wire logic [15:0] req_data,
   output logic done,
   output logic dev_psel,
   output logic dev_penable,
   output logic dev_pwrite,
   output logic [7:0] dev_paddr,
   output logic [31:0] dev_pwdata,
   input wire logic dev_pready
);
   mst_t r;
   mst_t n;

   always_comb begin
      n = r;
      done = r.busy && r.penable && dev_pready;
      if (!r.busy && req) begin
         n.busy = 1'b1;
         n.addr = req_addr;
         n.data = req_data;
      end else if (r.busy && !r.penable) begin
         n.penable = 1'b1;
      end else if (done) begin
         n.busy = 1'b0;
         n.penable = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign dev_psel = r.busy;
   assign dev_penable = r.penable;
   assign dev_pwrite = 1'b1;
   assign dev_paddr = r.addr;
   assign dev_pwdata = {16'h0000, r.data};

   a_bus_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      dev_psel && !(dev_penable && dev_pready) |=>
         dev_psel && $stable(dev_paddr) && $stable(dev_pwdata))
      else $error("request changed before pready");
   a_word_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
      dev_psel |-> dev_pwdata[31:16] == 16'h0000 && dev_pwrite)
      else $error("device write wider than 16 bits");
   a_access_next: assert property (@(posedge clk_sys) disable iff (sys_rst)
      dev_psel && !dev_penable |=> dev_psel && dev_penable)
      else $error("setup cycle not followed by access");
endmodule : dev_bus_master
`default_nettype wire

// ### logic/setup_entry_mem.sv
// sixteen-entry store of channel setup words with registered read
`timescale 1ns/100ps
`default_nettype none
module setup_entry_mem (
   input wire logic clk_sys,
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic [14:0] wdata,
   input wire logic [3:0] raddr,
   output logic [14:0] rdata
);
   logic [14:0] mem [16];
   logic [14:0] rdata_r;

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_r <= mem[raddr];
   end

   assign rdata = rdata_r;
endmodule : setup_entry_mem
`default_nettype wire

// ### tb/dev_board_model.sv
// behavioural model of the acquisition board behind its register bus
`timescale 1ns/100ps
`default_nettype none
`include "acq_map.svh"
module dev_board_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic dev_psel,
   input wire logic dev_penable,
   input wire logic dev_pwrite,
   input wire logic [7:0] dev_paddr,
   input wire logic [31:0] dev_pwdata,
   output logic dev_pready,
   input wire logic [3:0] lat
);
   logic [23:0] log_q[$];
   int bad_cnt = 0;
   logic [3:0] wait_r, wptr_r, sptr_r;
   logic [1:0] err_r;
   logic irq_r, done_r, armed_r, phase_r;
   logic [9:0] fifo_r;
   logic [2:0] cmd1_r;
   logic [15:0] sel_r, mode_r, iv_r, applied_r, left_r;
   logic [15:0] mem [16];
   logic acc;
   assign acc = dev_psel && dev_penable;
   // the answer comes lat+1 cycles into the access phase, never before
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         dev_pready <= 1'b0;
         wait_r <= 4'h0;
         armed_r <= 1'b0;
         err_r <= 2'b00;
         fifo_r <= 10'h0;
         sptr_r <= 4'h0;
         left_r <= 16'h0;
         phase_r <= 1'b0;
         cmd1_r <= 3'h0;
      end else begin
         dev_pready <= acc && !dev_pready && wait_r >= lat;
         wait_r <= (acc && !dev_pready) ? wait_r + 4'h1 : 4'h0;
         // a convert request every cycle against two-cycle conversions
         if (armed_r && left_r != 16'h0) begin
            phase_r <= !phase_r;
            if (phase_r) begin
               err_r[1] <= 1'b1;
            end else begin
               left_r <= left_r - 16'h1;
               if (fifo_r == 10'h200) err_r[0] <= 1'b1;
               else fifo_r <= fifo_r + 10'h1;
               if (!cmd1_r[2]) sptr_r <= (mem[sptr_r][15] || !cmd1_r[1]) ? 4'h0 : sptr_r + 4'h1;
            end
         end
         if (acc && dev_pready) begin
            log_q.push_back({dev_paddr, dev_pwdata[15:0]});
            if (dev_pwdata[31:16] !== 16'h0 || dev_pwrite !== 1'b1) bad_cnt++;
            case (dev_paddr)
               `DEV_ACQ_CLR: begin
                  err_r <= 2'b00;
                  irq_r <= 1'b0;
                  fifo_r <= 10'h0;
                  done_r <= 1'b0;
               end
               `DEV_SETUP_CLR: begin
                  wptr_r <= 4'h0;
                  sptr_r <= 4'h0;
               end
               `DEV_SETUP_LD: begin
                  applied_r <= mem[0];
                  sptr_r <= 4'h0;
               end
               `DEV_SETUP_WIN: begin
                  mem[wptr_r] <= dev_pwdata[15:0];
                  wptr_r <= wptr_r + 4'h1;
               end
               `DEV_CMD1: cmd1_r <= dev_pwdata[2:0];
               `DEV_ACQ_START: begin
                  armed_r <= 1'b1;
                  left_r <= 16'h0300;
               end
               `DEV_CTR_CMD: begin
                  sel_r <= dev_pwdata[15:0];
                  if (dev_pwdata[15:0] == `CNT_DISARM3) armed_r <= 1'b0;
               end
               `DEV_CTR_DATA: begin
                  if (sel_r == `CNT_SEL_MODE3) mode_r <= dev_pwdata[15:0];
                  else iv_r <= dev_pwdata[15:0];
               end
               default: bad_cnt++;
            endcase
         end
      end
   end
endmodule : dev_board_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench of the scan sequencer controller
`timescale 1ns/100ps
`default_nettype none
`include "acq_map.svh"
module testbench;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] lat = 4'h0;
   logic [31:0] prdata, dev_pwdata, rd;
   logic pready, pslverr, dev_psel, dev_penable, dev_pwrite, dev_pready, err;
   logic [7:0] dev_paddr;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   logic [23:0] ex[$];
   always #5 clk_sys = ~clk_sys;
   acquisition_scan_sequencer dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .dev_psel, .dev_penable, .dev_pwrite,
      .dev_paddr, .dev_pwdata, .dev_pready);
   dev_board_model dev (.clk_sys, .sys_rst, .dev_psel, .dev_penable, .dev_pwrite,
      .dev_paddr, .dev_pwdata, .dev_pready, .lat);
   task automatic complete_run();
      if (miscompares == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : xfer
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         xfer(1'b0, `REG_STATUS, 32'h0);
         n++;
      end while (rd[`ST_DONE] !== 1'b1 && n < 200);
   endtask : wait_done
   // issue one command and compare the board writes with ex
   task automatic op(input logic [3:0] c, input logic [3:0] l);
      lat <= l;
      dev.log_q.delete();
      xfer(1'b1, `REG_STATUS, 32'he);
      xfer(1'b1, `REG_CMD, {28'h0, c});
      wait_done();
      chk("status", 32'h2, rd & 32'hf);
      chk("write count", ex.size(), dev.log_q.size());
      foreach (ex[i])
         if (i < dev.log_q.size()) chk("device write", ex[i], dev.log_q[i]);
   endtask : op
   task automatic s_reset();
      xfer(1'b0, `REG_CFG, 32'h0);
      chk("cfg", {25'h0, `CFG_RST}, rd);
      xfer(1'b0, `REG_IV, 32'h0);
      chk("interval", {15'h0, `IV_RST}, rd);
      xfer(1'b0, `REG_CNT, 32'h0);
      chk("count", {28'h0, `CNT_RST}, rd);
      xfer(1'b0, `REG_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      xfer(1'b0, 8'h18, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
   endtask : s_reset
   task automatic s_clear();
      ex = '{{`DEV_ACQ_CLR, 16'h0}};
      op(4'h1, 4'h0);
      op(4'hf, 4'h3);
   endtask : s_clear
   task automatic s_load();
      logic [3:0] n;
      for (int k = 0; k < 2; k++) begin
         n = k ? 4'h2 : 4'h0;
         xfer(1'b1, `REG_CNT, {28'h0, n});
         ex = '{{`DEV_SETUP_CLR, 16'h0}};
         for (int i = 0; i <= n; i++) begin
            xfer(1'b1, `REG_ENTRY, {12'h0, i[3:0], 1'b0, 15'h1a0 + i[14:0]});
            ex.push_back({`DEV_SETUP_WIN, i == n, 15'h1a0 + i[14:0]});
         end
         ex.push_back({`DEV_SETUP_LD, 16'h0});
         op(4'h2, k ? 4'h3 : 4'h0);
      end
   endtask : s_load
   task automatic s_prog();
      logic [15:0] mw [7];
      logic [16:0] iv;
      mw = '{`MODE_5MHZ, `MODE_1MHZ, `MODE_100KHZ, `MODE_10KHZ, `MODE_1KHZ, `MODE_100HZ,
         `MODE_EXT};
      for (int t = 0; t < 7; t++) begin
         iv = t == 0 ? `IV_MIN : t == 6 ? `IV_MAX : t == 5 ? 17'hffff : 17'h1234 + t[16:0];
         xfer(1'b1, `REG_CFG, {25'h0, t[2:0], 4'h0});
         xfer(1'b1, `REG_IV, {15'h0, iv});
         ex = '{{`DEV_CTR_CMD, `CNT_SEL_MODE3}, {`DEV_CTR_DATA, mw[t]},
            {`DEV_CTR_CMD, `CNT_SEL_LOAD3}, {`DEV_CTR_DATA, `IV_PRELOAD},
            {`DEV_CTR_CMD, `CNT_LOAD3}, {`DEV_CTR_CMD, `CNT_STEP3},
            {`DEV_CTR_DATA, iv[15:0]}, {`DEV_CTR_CMD, `CNT_ARM3}};
         op(4'h4, t[3:0]);
      end
      xfer(1'b1, `REG_CFG, 32'h8);
      ex = '{{`DEV_CTR_CMD, `CNT_DISARM3}};
      op(4'h4, 4'h1);
   endtask : s_prog
   task automatic s_bad();
      for (int b = 0; b < 2; b++) begin
         xfer(1'b1, `REG_CFG, b ? 32'h70 : 32'h0);
         xfer(1'b1, `REG_IV, b ? 32'h2 : 32'h1);
         dev.log_q.delete();
         xfer(1'b1, `REG_STATUS, 32'he);
         xfer(1'b1, `REG_CMD, 32'h4);
         xfer(1'b0, `REG_STATUS, 32'h0);
         chk("bad prog status", 32'h8, rd);
         chk("bad prog writes", 32'h0, dev.log_q.size());
      end
   endtask : s_bad
   task automatic s_start();
      for (int s = 0; s < 2; s++) begin
         xfer(1'b1, `REG_CFG, s ? 32'h1 : 32'h7);
         ex = '{{`DEV_ACQ_CLR, 16'h0}, {`DEV_CMD1, 13'h0, s ? 3'h1 : 3'h7},
            {`DEV_ACQ_START, 16'h0}};
         op(4'h8, 4'h2);
      end
   endtask : s_start
   task automatic s_refuse();
      xfer(1'b1, `REG_CFG, 32'h0);
      xfer(1'b1, `REG_CNT, 32'h2);
      lat <= 4'h5;
      xfer(1'b1, `REG_STATUS, 32'he);
      xfer(1'b1, `REG_CMD, 32'h2);
      xfer(1'b1, `REG_CFG, 32'h7);
      xfer(1'b0, `REG_STATUS, 32'h0);
      chk("busy refused", 32'h5, rd & 32'h5);
      wait_done();
      xfer(1'b0, `REG_CFG, 32'h0);
      chk("cfg kept", 32'h0, rd);
   endtask : s_refuse
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      s_reset();
      s_clear();
      s_load();
      s_prog();
      s_bad();
      s_start();
      s_refuse();
      chk("bus format", 32'h0, dev.bad_cnt);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
